// >>> bench/sync_serial_partner.sv
`timescale 1ns/1ps
module sync_serial_partner (
  // system clock for pacing
  input wire logic i_clk,
  // resolved pin levels
  input wire logic i_line_clk,
  input wire logic i_line_data,
  // pin drives
  output logic o_ck,
  output logic o_dt,
  output logic o_dt_oe,
  // last captured character
  output logic [8:0] o_got
);
  logic [8:0] word;
  int nb;
  int idx;
  initial begin
    o_ck = 1'b0;
    o_dt = 1'b0;
    o_dt_oe = 1'b0;
    o_got = 9'h000;
    word = 9'h000;
    nb = 9;
    idx = 0;
  end
  // external bit clock, idle low between frames; data taken at the falling edge
  task automatic clock_bits(input int n, input int half);
    for (int b = 0; b < n; b++) begin
      @(posedge i_clk);
      o_ck <= 1'b1;
      repeat (half) @(posedge i_clk);
      o_got <= {i_line_data, o_got[8:1]};
      o_ck <= 1'b0;
      repeat (half - 1) @(posedge i_clk);
    end
  endtask
  // data source for master reception, lsb first, repeating the same character
  task automatic load(input logic [8:0] w, input int n);
    word = w;
    nb = n;
    idx = 0;
    o_dt_oe <= 1'b1;
  endtask
  // new bit on each rising clock edge so it is settled at the falling edge
  always @(posedge i_line_clk) begin
    if (o_dt_oe) begin
      o_dt <= word[idx];
      idx <= (idx == nb - 1) ? 0 : idx + 1;
    end
  end
endmodule

// >>> bench/sync_serial_xcvr_tb_top.sv
`timescale 1ns/1ps
`include "sync_serial_consts.svh"
module sync_serial_xcvr_tb_top;
  import sync_serial_pkg::*;
  logic I_CLK, I_SYS_RST, I_READ, I_WRITE;
  bus_addr_t I_ADDRESS;
  bus_word_t I_WRITEDATA, O_READDATA;
  logic [3:0] I_BYTEENABLE;
  logic O_WAITREQUEST, O_DATA_OUT, O_DATA_OE, O_CLK_OUT, O_CLK_OE, O_WAKE, O_IRQ;
  logic p_ck, p_dt, p_dt_oe, line_clk, line_data, last_data, prev_clk;
  logic [8:0] p_got, rd;
  int failures, total_checks, pulses, hi_len, last_hi, p0, n;
  // partner drives the clock only while the device has released it
  assign line_clk = O_CLK_OE ? O_CLK_OUT : p_ck;
  assign line_data = O_DATA_OE ? O_DATA_OUT : (p_dt_oe ? p_dt : ~last_data);
  sync_serial_xcvr dut (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
    .I_WRITE(I_WRITE), .I_BYTEENABLE(I_BYTEENABLE), .I_WRITEDATA(I_WRITEDATA),
    .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST), .I_DATA_IN(line_data),
    .O_DATA_OUT(O_DATA_OUT), .O_DATA_OE(O_DATA_OE), .I_CLK_IN(line_clk),
    .O_CLK_OUT(O_CLK_OUT), .O_CLK_OE(O_CLK_OE), .O_WAKE(O_WAKE), .O_IRQ(O_IRQ)
  );
  sync_serial_partner p (
    .i_clk(I_CLK), .i_line_clk(line_clk), .i_line_data(line_data), .o_ck(p_ck),
    .o_dt(p_dt), .o_dt_oe(p_dt_oe), .o_got(p_got)
  );
  initial begin
    I_CLK = 1'b0;
    forever #50 I_CLK = ~I_CLK;
  end
  // pulse counter and high time of the clock line
  always @(posedge I_CLK) begin
    last_data <= line_data;
    prev_clk <= line_clk;
    hi_len <= line_clk ? hi_len + 1 : 0;
    if (line_clk && !prev_clk) pulses <= pulses + 1;
    if (!line_clk && prev_clk) last_hi <= hi_len;
  end
  task automatic test_done;
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input bus_addr_t a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge I_CLK);
    I_ADDRESS <= a;
    I_WRITE <= wr;
    I_READ <= ~wr;
    I_WRITEDATA <= {24'h00_0000, d};
    do begin
      @(posedge I_CLK);
      k++;
    end while (O_WAITREQUEST !== 1'b0 && k < 20);
    rd = {1'b0, O_READDATA[7:0]};
    I_READ <= 1'b0;
    I_WRITE <= 1'b0;
    if (O_WAITREQUEST !== 1'b0) begin
      failures++;
      test_done();
    end
  endtask
  task automatic wait_wake;
    int k;
    k = 0;
    while (O_WAKE !== 1'b1 && k < 30000) begin
      @(posedge I_CLK);
      k++;
    end
    if (O_WAKE !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask
  task automatic settle;
    @(posedge I_CLK);
    @(posedge I_CLK);
    #1;
  endtask
  initial begin
    I_SYS_RST = 1'b1;
    I_READ = 1'b0;
    I_WRITE = 1'b0;
    I_ADDRESS = 6'h00;
    I_WRITEDATA = 32'h0000_0000;
    I_BYTEENABLE = 4'hF;
    last_data = 1'b0;
    prev_clk = 1'b0;
    failures = 0;
    total_checks = 0;
    pulses = 0;
    hi_len = 0;
    last_hi = 0;
    repeat (3) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    // unmapped write dropped, then every place reads zero except the TRMT and RCIDL status bits
    bus(1'b1, 6'h2C, 8'hFF);
    for (int a = 0; a < 12; a++) begin
      bus(1'b0, bus_addr_t'(a * 4), 8'h00);
      check("reset value", rd, a == 5 ? 9'h002 : (a == 6 ? 9'h040 : 9'h000));
    end
    bus(1'b1, `SS_OFS_BAUD_CONTROL, 8'hFF);
    bus(1'b0, `SS_OFS_BAUD_CONTROL, 8'h00);
    check("baud control", rd & 9'h0BF, 9'h0BB);
    I_BYTEENABLE <= 4'h0;
    bus(1'b1, `SS_OFS_BAUD_CONTROL, 8'h00);
    I_BYTEENABLE <= 4'hF;
    bus(1'b0, `SS_OFS_BAUD_CONTROL, 8'h00);
    check("byte enable off", rd & 9'h0BF, 9'h0BB);
    // slave transmission of two queued nine-bit words, true data polarity
    bus(1'b1, `SS_OFS_BAUD_CONTROL, 8'h00);
    bus(1'b1, `SS_OFS_INTCTL, 8'h01);
    bus(1'b1, `SS_OFS_ENABLES, 8'h10);
    bus(1'b1, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'h80);
    bus(1'b1, `SS_OFS_TRANSMIT_STATUS_CONTROL, 8'h71);
    settle();
    check("clock oe slave", 9'(O_CLK_OE), 9'h000);
    check("data oe transmit", 9'(O_DATA_OE), 9'h001);
    bus(1'b1, `SS_OFS_TXDATA, 8'hA5);
    bus(1'b1, `SS_OFS_TRANSMIT_STATUS_CONTROL, 8'h70);
    bus(1'b1, `SS_OFS_TXDATA, 8'h3C);
    bus(1'b0, `SS_OFS_FLAGS, 8'h00);
    check("tx flag held", rd & 9'h010, 9'h000);
    check("no wake yet", 9'(O_WAKE), 9'h000);
    p.clock_bits(9, 8);
    check("first word", p_got, 9'h1A5);
    wait_wake();
    check("no vector", 9'(O_IRQ), 9'h000);
    bus(1'b1, `SS_OFS_INTCTL, 8'h03);
    settle();
    check("vector", 9'(O_IRQ), 9'h001);
    p.clock_bits(9, 8);
    check("second word", p_got, 9'h03C);
    // master single reception at two divider settings
    bus(1'b1, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'h00);
    bus(1'b1, `SS_OFS_ENABLES, 8'h20);
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, `SS_OFS_TRANSMIT_STATUS_CONTROL, c == 0 ? 8'h90 : 8'h94);
      bus(1'b1, `SS_OFS_BAUD_CONTROL, c == 0 ? 8'h08 : 8'h00);
      bus(1'b1, `SS_OFS_DIV_HIGH, 8'h01);
      bus(1'b1, `SS_OFS_DIV_LOW, 8'h03);
      p.load(9'h15A, 9);
      bus(1'b1, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'hC0);
      settle();
      check("clock oe master", 9'(O_CLK_OE), 9'h001);
      check("data oe receive", 9'(O_DATA_OE), 9'h000);
      p0 = pulses;
      bus(1'b1, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'hE0);
      wait_wake();
      check("pulse count", 9'(pulses - p0), 9'h009);
      check("half period", 9'(last_hi == (c == 0 ? 1040 : 4)), 9'h001);
      bus(1'b0, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'h00);
      check("status", rd, 9'h0C1);
      bus(1'b0, `SS_OFS_RCDATA, 8'h00);
      check("data", rd, 9'h05A);
      bus(1'b0, `SS_OFS_FLAGS, 8'h00);
      check("rx flag", rd & 9'h020, 9'h000);
    end
    // continuous reception into overrun, cleared by each of the two ways
    for (int k = 0; k < 2; k++) begin
      p.load(9'h0C3, 9);
      p0 = pulses;
      bus(1'b1, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'hD0);
      n = 0;
      do begin
        bus(1'b0, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'h00);
        n++;
      end while (rd[1] !== 1'b1 && n < 300);
      check("overrun", rd & 9'h002, 9'h002);
      repeat (100) @(posedge I_CLK);
      check("stopped", 9'(pulses - p0), 9'h01B);
      bus(1'b1, `SS_OFS_RECEIVE_STATUS_CONTROL, k == 0 ? 8'hC0 : 8'h00);
      bus(1'b0, `SS_OFS_RECEIVE_STATUS_CONTROL, 8'h00);
      check("overrun cleared", rd & 9'h002, 9'h000);
      if (k == 0) begin
        for (int j = 0; j < 2; j++) begin
          bus(1'b0, `SS_OFS_RCDATA, 8'h00);
          check("kept data", rd, 9'h0C3);
        end
      end
    end
    settle();
    check("port off", 9'(O_CLK_OE), 9'h000);
    test_done();
  end
endmodule

// >>> core/sync_serial_consts.svh
`ifndef SYNC_SERIAL_CONSTS_SVH
`define SYNC_SERIAL_CONSTS_SVH

// register byte offsets
`define SS_OFS_FLAGS 6'h00
`define SS_OFS_ENABLES 6'h04
`define SS_OFS_PRIORITY 6'h08
`define SS_OFS_RECEIVE_STATUS_CONTROL 6'h0C
`define SS_OFS_RCDATA 6'h10
`define SS_OFS_TRANSMIT_STATUS_CONTROL 6'h14
`define SS_OFS_BAUD_CONTROL 6'h18
`define SS_OFS_DIV_HIGH 6'h1C
`define SS_OFS_DIV_LOW 6'h20
`define SS_OFS_TXDATA 6'h24
`define SS_OFS_INTCTL 6'h28

// flags and enables
`define SS_RX_FLAG_BIT 5
`define SS_TX_FLAG_BIT 4
// receive status and control
`define SS_PORT_EN_BIT 7
`define SS_RX9_BIT 6
`define SS_SINGLE_RECEIVE_ENABLE_BIT 5
`define SS_CONTINUOUS_RECEIVE_ENABLE_BIT 4
`define SS_FRAMING_ERROR_BIT 2
`define SS_OVERRUN_ERROR_BIT 1
`define SS_RECEIVED_NINTH_BIT_BIT 0
`define SS_RECEIVE_STATUS_CONTROL_WMASK 8'hF8
// transmit status and control
`define SS_CLOCK_SOURCE_SELECT_BIT 7
`define SS_TX9_BIT 6
`define SS_TRANSMIT_ENABLE_BIT 5
`define SS_SYNC_BIT 4
`define SS_HIGH_SPEED_BAUD_BIT 2
`define SS_TRMT_BIT 1
`define SS_TRANSMIT_NINTH_BIT_BIT 0
`define SS_TRANSMIT_STATUS_CONTROL_WMASK 8'hFD
// baud control
`define SS_RCIDL_BIT 6
`define SS_DTRXP_BIT 5
`define SS_WIDE_BAUD_DIVIDER_BIT 3
`define SS_BAUD_WMASK 8'hBB
// own interrupt control
`define SS_GIE_BIT 1
`define SS_PERIPHERAL_INTERRUPT_ENABLE_BIT 0

`define SS_REG_RESET 8'h00
`define SS_WORD_ZERO 32'h0000_0000
`define SS_LOW_SPEED_PRESCALE 2'h3
`define SS_CHAR_BITS_8 4'h8
`define SS_CHAR_BITS_9 4'h9
`define SS_FIFO_FULL 2'h2

`endif

// >>> core/sync_serial_pkg.sv
package sync_serial_pkg;
  typedef logic [31:0] bus_word_t;
  typedef logic [5:0] bus_addr_t;
  typedef logic [8:0] char_t;
  typedef enum logic [1:0] {MODE_OFF, MODE_MASTER, MODE_SLAVE} mode_e;
endpackage

// >>> core/sync_serial_xcvr.sv
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sync_serial_consts.svh"
module sync_serial_xcvr (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // avalon-mm slave
  input wire sync_serial_pkg::bus_addr_t I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [3:0] I_BYTEENABLE,
  input wire sync_serial_pkg::bus_word_t I_WRITEDATA,
  output sync_serial_pkg::bus_word_t O_READDATA,
  output logic O_WAITREQUEST,
  // data line
  input wire logic I_DATA_IN,
  output logic O_DATA_OUT,
  output logic O_DATA_OE,
  // clock line
  input wire logic I_CLK_IN,
  output logic O_CLK_OUT,
  output logic O_CLK_OE,
  // processor wake and interrupt request
  output logic O_WAKE,
  output logic O_IRQ
);
  import sync_serial_pkg::*;

  // register state
  logic [7:0] flags_rw, enables, priority_one, receive_status_control, transmit_status_control, baud_control, div_high, div_low, intctl;
  logic [7:0] next_flags_rw, next_enables, next_priority_one, next_receive_status_control, next_transmit_status_control;
  logic [7:0] next_baud_control, next_div_high, next_div_low, next_intctl;
  logic waitreq, next_waitreq;
  bus_word_t readdata, next_readdata;
  // transmit state
  logic hold_full, tsr_full, tx_bit;
  logic next_hold_full, next_tsr_full, next_tx_bit;
  char_t hold_data, transmit_shift_register, next_hold_data, next_tsr;
  logic [3:0] tx_cnt, next_tx_cnt;
  // receive state
  char_t receive_shift_register, next_rsr;
  char_t fifo [0:1];
  char_t next_fifo [0:1];
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [1:0] fill, next_fill;
  logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic overrun, ovr_continuous_receive_enable, next_overrun, next_ovr_continuous_receive_enable;
  // bit clock generator
  logic [15:0] gen_cnt, next_gen_cnt;
  logic [1:0] pre, next_pre;
  logic gen_clk, next_gen_clk, clk_prev;
  // pins and outputs
  logic data_s, clk_s;
  logic data_oe, clk_out, clk_oe, wake, irq;
  logic next_data_oe, next_clk_out, next_clk_oe, next_wake, next_irq;

  sync_two_flop #(.WIDTH(2)) u_pin_sync (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_async({I_DATA_IN, I_CLK_IN}),
    .o_sync({data_s, clk_s})
  );

  // decoded controls
  logic port_en, sync_on, single_receive_enable, continuous_receive_enable, transmit_enable, tx9, rx9, dtrxp, high_speed_baud, wide_baud_divider;
  logic rx_mode, tx_mode, rx_active, tx_flag, rx_flag;
  logic bus_req, bus_done, wr_en, transmit_holding_port_wr, receive_data_port_pop;
  logic gen_run, tick, pre_done, lead, trail, rx_done, push;
  logic [15:0] div_val;
  logic [3:0] tx_bits, rx_bits;
  char_t rx_char;
  mode_e mode;

  always_comb begin
    port_en = receive_status_control[`SS_PORT_EN_BIT];
    sync_on = transmit_status_control[`SS_SYNC_BIT] & port_en;
    single_receive_enable = receive_status_control[`SS_SINGLE_RECEIVE_ENABLE_BIT];
    continuous_receive_enable = receive_status_control[`SS_CONTINUOUS_RECEIVE_ENABLE_BIT];
    transmit_enable = transmit_status_control[`SS_TRANSMIT_ENABLE_BIT];
    tx9 = transmit_status_control[`SS_TX9_BIT];
    rx9 = receive_status_control[`SS_RX9_BIT];
    dtrxp = baud_control[`SS_DTRXP_BIT];
    high_speed_baud = transmit_status_control[`SS_HIGH_SPEED_BAUD_BIT];
    wide_baud_divider = baud_control[`SS_WIDE_BAUD_DIVIDER_BIT];
    if (!sync_on) begin
      mode = MODE_OFF;
    end else if (transmit_status_control[`SS_CLOCK_SOURCE_SELECT_BIT]) begin
      mode = MODE_MASTER;
    end else begin
      mode = MODE_SLAVE;
    end
    rx_mode = single_receive_enable | continuous_receive_enable;
    tx_mode = sync_on & ~rx_mode & transmit_enable;
    rx_active = sync_on & rx_mode & ~overrun;
    tx_flag = transmit_enable & ~hold_full;
    rx_flag = fill != 2'h0;
    tx_bits = tx9 ? `SS_CHAR_BITS_9 : `SS_CHAR_BITS_8;
    rx_bits = rx9 ? `SS_CHAR_BITS_9 : `SS_CHAR_BITS_8;
    div_val = wide_baud_divider ? {div_high, div_low} : {8'h00, div_low};
    bus_req = I_READ | I_WRITE;
    bus_done = bus_req & ~waitreq;
    wr_en = I_WRITE & bus_done & I_BYTEENABLE[0];
    transmit_holding_port_wr = wr_en & (I_ADDRESS == `SS_OFS_TXDATA);
    receive_data_port_pop = I_READ & bus_done & (I_ADDRESS == `SS_OFS_RCDATA) & rx_flag;
    gen_run = (mode == MODE_MASTER) & (rx_active | (tx_mode & tsr_full));
    pre_done = high_speed_baud | (pre == `SS_LOW_SPEED_PRESCALE);
    tick = gen_run & pre_done & (gen_cnt == 16'h0000);
    lead = 1'b0;
    trail = 1'b0;
    unique case (mode)
      MODE_OFF: begin
        lead = 1'b0;
      end
      MODE_MASTER: begin
        lead = tick & ~gen_clk;
        trail = tick & gen_clk;
      end
      MODE_SLAVE: begin
        lead = clk_s & ~clk_prev;
        trail = ~clk_s & clk_prev;
      end
    endcase
    rx_char = receive_shift_register;
    rx_char[rx_cnt] = data_s ^ dtrxp;
    rx_done = rx_active & trail & (rx_cnt == rx_bits - 4'h1);
    push = rx_done & (fill != `SS_FIFO_FULL);
  end

  // register file and bus answer
  always_comb begin
    next_flags_rw = flags_rw;
    next_enables = enables;
    next_priority_one = priority_one;
    next_receive_status_control = receive_status_control;
    next_transmit_status_control = transmit_status_control;
    next_baud_control = baud_control;
    next_div_high = div_high;
    next_div_low = div_low;
    next_intctl = intctl;
    next_waitreq = ~(bus_req & waitreq);
    next_readdata = `SS_WORD_ZERO;
    if (rx_done) begin
      next_receive_status_control[`SS_SINGLE_RECEIVE_ENABLE_BIT] = 1'b0;
    end
    if (wr_en) begin
      unique case (I_ADDRESS)
        `SS_OFS_FLAGS: next_flags_rw = I_WRITEDATA[7:0];
        `SS_OFS_ENABLES: next_enables = I_WRITEDATA[7:0];
        `SS_OFS_PRIORITY: next_priority_one = I_WRITEDATA[7:0];
        `SS_OFS_RECEIVE_STATUS_CONTROL: next_receive_status_control = I_WRITEDATA[7:0] & `SS_RECEIVE_STATUS_CONTROL_WMASK;
        `SS_OFS_TRANSMIT_STATUS_CONTROL: next_transmit_status_control = I_WRITEDATA[7:0] & `SS_TRANSMIT_STATUS_CONTROL_WMASK;
        `SS_OFS_BAUD_CONTROL: next_baud_control = I_WRITEDATA[7:0] & `SS_BAUD_WMASK;
        `SS_OFS_DIV_HIGH: next_div_high = I_WRITEDATA[7:0];
        `SS_OFS_DIV_LOW: next_div_low = I_WRITEDATA[7:0];
        `SS_OFS_INTCTL: next_intctl = I_WRITEDATA[7:0];
        default: next_intctl = intctl;
      endcase
    end
    if (bus_req & waitreq & I_READ) begin
      unique case (I_ADDRESS)
        `SS_OFS_FLAGS: begin
          next_readdata[7:0] = flags_rw;
          next_readdata[`SS_RX_FLAG_BIT] = rx_flag;
          next_readdata[`SS_TX_FLAG_BIT] = tx_flag;
        end
        `SS_OFS_ENABLES: next_readdata[7:0] = enables;
        `SS_OFS_PRIORITY: next_readdata[7:0] = priority_one;
        `SS_OFS_RECEIVE_STATUS_CONTROL: begin
          next_readdata[7:0] = receive_status_control;
          next_readdata[`SS_OVERRUN_ERROR_BIT] = overrun;
          next_readdata[`SS_FRAMING_ERROR_BIT] = 1'b0;
          next_readdata[`SS_RECEIVED_NINTH_BIT_BIT] = fifo[rd_ptr][8];
        end
        `SS_OFS_RCDATA: next_readdata[7:0] = fifo[rd_ptr][7:0];
        `SS_OFS_TRANSMIT_STATUS_CONTROL: begin
          next_readdata[7:0] = transmit_status_control;
          next_readdata[`SS_TRMT_BIT] = ~tsr_full;
        end
        `SS_OFS_BAUD_CONTROL: begin
          next_readdata[7:0] = baud_control;
          next_readdata[`SS_RCIDL_BIT] = rx_cnt == 4'h0;
        end
        `SS_OFS_DIV_HIGH: next_readdata[7:0] = div_high;
        `SS_OFS_DIV_LOW: next_readdata[7:0] = div_low;
        `SS_OFS_INTCTL: next_readdata[7:0] = intctl;
        default: next_readdata = `SS_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      flags_rw <= `SS_REG_RESET;
      enables <= `SS_REG_RESET;
      priority_one <= `SS_REG_RESET;
      receive_status_control <= `SS_REG_RESET;
      transmit_status_control <= `SS_REG_RESET;
      baud_control <= `SS_REG_RESET;
      div_high <= `SS_REG_RESET;
      div_low <= `SS_REG_RESET;
      intctl <= `SS_REG_RESET;
      waitreq <= 1'b1;
      readdata <= `SS_WORD_ZERO;
    end else begin
      flags_rw <= next_flags_rw;
      enables <= next_enables;
      priority_one <= next_priority_one;
      receive_status_control <= next_receive_status_control;
      transmit_status_control <= next_transmit_status_control;
      baud_control <= next_baud_control;
      div_high <= next_div_high;
      div_low <= next_div_low;
      intctl <= next_intctl;
      waitreq <= next_waitreq;
      readdata <= next_readdata;
    end
  end

  // master bit clock generator
  always_comb begin
    next_gen_cnt = gen_cnt;
    next_pre = pre;
    next_gen_clk = gen_clk;
    if (!gen_run) begin
      next_gen_cnt = div_val;
      next_pre = 2'h0;
      next_gen_clk = 1'b0;
    end else if (pre_done) begin
      next_pre = 2'h0;
      if (gen_cnt == 16'h0000) begin
        next_gen_cnt = div_val;
        next_gen_clk = ~gen_clk;
      end else begin
        next_gen_cnt = gen_cnt - 16'h0001;
      end
    end else begin
      next_pre = pre + 2'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      gen_cnt <= 16'h0000;
      pre <= 2'h0;
      gen_clk <= 1'b0;
      clk_prev <= 1'b0;
    end else begin
      gen_cnt <= next_gen_cnt;
      pre <= next_pre;
      gen_clk <= next_gen_clk;
      clk_prev <= clk_s;
    end
  end

  // transmitter
  always_comb begin
    next_hold_full = hold_full;
    next_hold_data = hold_data;
    next_tsr = transmit_shift_register;
    next_tsr_full = tsr_full;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    if (tx_mode & tsr_full & lead) begin
      next_tx_bit = transmit_shift_register[0] ^ dtrxp;
    end
    if (tx_mode & tsr_full & trail) begin
      next_tsr = transmit_shift_register >> 1;
      next_tx_cnt = tx_cnt + 4'h1;
      if (tx_cnt == tx_bits - 4'h1) begin
        next_tsr_full = 1'b0;
      end
    end
    if (tx_mode & ~tsr_full & hold_full) begin
      next_tsr = hold_data;
      next_tsr_full = 1'b1;
      next_tx_cnt = 4'h0;
      next_hold_full = 1'b0;
    end
    if (transmit_holding_port_wr) begin
      next_hold_data = {transmit_status_control[`SS_TRANSMIT_NINTH_BIT_BIT] & tx9, I_WRITEDATA[7:0]};
      next_hold_full = 1'b1;
    end
    if (!sync_on) begin
      next_hold_full = 1'b0;
      next_tsr_full = 1'b0;
      next_tx_cnt = 4'h0;
      next_tx_bit = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      hold_full <= 1'b0;
      hold_data <= 9'h000;
      transmit_shift_register <= 9'h000;
      tsr_full <= 1'b0;
      tx_cnt <= 4'h0;
      tx_bit <= 1'b0;
    end else begin
      hold_full <= next_hold_full;
      hold_data <= next_hold_data;
      transmit_shift_register <= next_tsr;
      tsr_full <= next_tsr_full;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
    end
  end

  // receiver and two-character buffer
  always_comb begin
    next_rsr = receive_shift_register;
    next_rx_cnt = rx_cnt;
    next_fifo = fifo;
    next_fill = fill;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_overrun = overrun;
    next_ovr_continuous_receive_enable = ovr_continuous_receive_enable;
    if (!rx_active) begin
      next_rsr = 9'h000; // partial character dropped
      next_rx_cnt = 4'h0;
    end else if (trail) begin
      next_rsr = rx_char;
      next_rx_cnt = rx_cnt + 4'h1;
      if (rx_done) begin
        next_rsr = 9'h000;
        next_rx_cnt = 4'h0;
      end
    end
    if (receive_data_port_pop) begin
      next_rd_ptr = ~rd_ptr;
      next_fill = fill - 2'h1;
    end
    if ((ovr_continuous_receive_enable & ~continuous_receive_enable) | (~ovr_continuous_receive_enable & ~continuous_receive_enable & receive_data_port_pop)) begin
      next_overrun = 1'b0;
    end
    if (push) begin
      next_fifo[wr_ptr] = rx9 ? rx_char : {1'b0, rx_char[7:0]};
      next_wr_ptr = ~wr_ptr;
      next_fill = next_fill + 2'h1;
    end else if (rx_done) begin
      next_overrun = 1'b1;
      next_ovr_continuous_receive_enable = continuous_receive_enable;
    end
    if (!port_en) begin
      next_fill = 2'h0;
      next_rd_ptr = 1'b0;
      next_wr_ptr = 1'b0;
      next_overrun = 1'b0;
      next_ovr_continuous_receive_enable = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      receive_shift_register <= 9'h000;
      rx_cnt <= 4'h0;
      fifo[0] <= 9'h000;
      fifo[1] <= 9'h000;
      fill <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      overrun <= 1'b0;
      ovr_continuous_receive_enable <= 1'b0;
    end else begin
      receive_shift_register <= next_rsr;
      rx_cnt <= next_rx_cnt;
      fifo <= next_fifo;
      fill <= next_fill;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      overrun <= next_overrun;
      ovr_continuous_receive_enable <= next_ovr_continuous_receive_enable;
    end
  end

  // pin drivers and wake
  always_comb begin
    next_data_oe = tx_mode;
    next_clk_oe = mode == MODE_MASTER;
    next_clk_out = gen_clk;
    next_wake = intctl[`SS_PERIPHERAL_INTERRUPT_ENABLE_BIT] & ((enables[`SS_TX_FLAG_BIT] & tx_flag) |
      (enables[`SS_RX_FLAG_BIT] & rx_flag));
    next_irq = next_wake & intctl[`SS_GIE_BIT];
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      data_oe <= 1'b0;
      clk_oe <= 1'b0;
      clk_out <= 1'b0;
      wake <= 1'b0;
      irq <= 1'b0;
    end else begin
      data_oe <= next_data_oe;
      clk_oe <= next_clk_oe;
      clk_out <= next_clk_out;
      wake <= next_wake;
      irq <= next_irq;
    end
  end

  always_comb begin
    O_READDATA = readdata;
    O_WAITREQUEST = waitreq;
    O_DATA_OUT = tx_bit;
    O_DATA_OE = data_oe;
    O_CLK_OUT = clk_out;
    O_CLK_OE = clk_oe;
    O_WAKE = wake;
    O_IRQ = irq;
  end

  logic rd_baud;
  always_ff @(posedge I_CLK) begin
    rd_baud <= I_READ & waitreq & (I_ADDRESS == `SS_OFS_BAUD_CONTROL);
  end

  AST_SLAVE_CLK: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == MODE_SLAVE) |=> !O_CLK_OE) else $error("clock driven in slave mode");
  AST_RX_NO_DRIVE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    rx_mode |=> !O_DATA_OE) else $error("data driven while receiving");
  AST_PORT_OFF: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !port_en |=> (fill == 2'h0) && !overrun && !tsr_full && !hold_full)
    else $error("transceiver not reset by port disable");
  AST_TX_LOAD: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (tx_mode && !tsr_full && hold_full && !transmit_holding_port_wr && !$fell(port_en)) |=> tsr_full && !hold_full)
    else $error("holding word not moved to shifter");
  AST_TX_HELD: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (tsr_full && hold_full && !enables[`SS_RX_FLAG_BIT]) |-> !tx_flag ##1 !O_WAKE)
    else $error("transmit flag set while word held");
  AST_TX_NEXT: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (tx_mode && $fell(tsr_full) && hold_full && !transmit_holding_port_wr) |=> tsr_full && tx_flag)
    else $error("second word not moved after first finished");
  AST_WAKE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (intctl[`SS_PERIPHERAL_INTERRUPT_ENABLE_BIT] && enables[`SS_TX_FLAG_BIT] && tx_flag) |=> O_WAKE ##0
    (O_IRQ == $past(intctl[`SS_GIE_BIT]))) else $error("transmit wake missing");
  AST_RX_FLAG: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (push && port_en) |=> rx_flag) else $error("receive flag not set");
  AST_SINGLE_RECEIVE_ENABLE_AUTO: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (rx_done && !wr_en) |=> !single_receive_enable) else $error("single receive enable not cleared");
  AST_BIT2_ZERO: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    rd_baud |-> !O_READDATA[2]) else $error("baud control bit 2 not zero");
  AST_OVR_STOP: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (overrun && port_en && !receive_data_port_pop) |-> !rx_active ##1 (fill == $past(fill)))
    else $error("reception during overrun");
  AST_LEAD_BIT: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (tx_mode && tsr_full && lead) |=> O_DATA_OUT == ($past(transmit_shift_register[0]) ^ $past(dtrxp)))
    else $error("data bit not changed on leading edge");
endmodule

// >>> core/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
